// ==== rtl/cirq_pkg.sv ====
// Shared constants and carrier types for the interrupt and I/O limit slice
package cirq_pkg;

   // ------------------------------------------------------------------
   // Configuration offsets (byte addresses in configuration space)
   // ------------------------------------------------------------------
   localparam logic [7:0]  CIRQ_OFF_IO_WIN0_LIMIT  = 8'h30;
   localparam logic [7:0]  CIRQ_OFF_IO_WIN1_LIMIT  = 8'h38;
   localparam logic [7:0]  CIRQ_OFF_IRQ_SCRATCH    = 8'h3C;
   localparam logic [7:0]  CIRQ_OFF_IRQ_PIN        = 8'h3D;

   // ------------------------------------------------------------------
   // Field positions and counts
   // ------------------------------------------------------------------
   localparam int          CIRQ_LIMIT_LSB          = 2;
   localparam int          CIRQ_LIMIT_MSB          = 15;
   localparam int          CIRQ_PIN_LANE           = 1;
   localparam int          CIRQ_NUM_FUNC           = 3;
   localparam int          CIRQ_NUM_WIN            = 2;
   localparam int          CIRQ_PAIR_MERGE_BIT     = 29;
   localparam int          CIRQ_ALL_MERGE_BIT      = 28;

   // ------------------------------------------------------------------
   // Reset and fixed read values
   // ------------------------------------------------------------------
   localparam logic [31:0] CIRQ_LIMIT_RESET        = 32'h0000_0000;
   localparam logic [7:0]  CIRQ_SCRATCH_RESET      = 8'hFF;
   localparam logic [7:0]  CIRQ_PIN_FIRST          = 8'h01;
   localparam logic [7:0]  CIRQ_PIN_SECOND         = 8'h02;
   localparam logic [7:0]  CIRQ_PIN_THIRD          = 8'h03;
   localparam logic [31:0] CIRQ_READ_ZERO          = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [1:0]  func;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cirq_cfg_req_s;

   typedef struct packed
   {
      logic [31:0] win1_limit;
      logic [31:0] win0_limit;
      logic [7:0]  scratch;
   } cirq_func_state_s;

endpackage

// ==== rtl/cirq_func_regs.sv ====
// Writable configuration registers of one function
`timescale 1ns/1ps

module cirq_func_regs
   import cirq_pkg::*;
#(
   parameter bit       HAS_IO_WINDOWS = 1'b1
)
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             wr_en,
   input  wire logic [7:0]       addr,
   input  wire logic [3:0]       be,
   input  wire logic [31:0]      wdata,
   output cirq_func_state_s      state
);

   cirq_func_state_s state_reg;
   cirq_func_state_s state_next;

   // ------------------------------------------------------------------
   // Next values
   // ------------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      if (wr_en && HAS_IO_WINDOWS && addr == CIRQ_OFF_IO_WIN0_LIMIT)
      begin
         if (be[0])
            state_next.win0_limit[7:CIRQ_LIMIT_LSB] =
               wdata[7:CIRQ_LIMIT_LSB];
         if (be[1])
            state_next.win0_limit[CIRQ_LIMIT_MSB:8] =
               wdata[CIRQ_LIMIT_MSB:8];
      end
      else if (wr_en && HAS_IO_WINDOWS &&
               addr == CIRQ_OFF_IO_WIN1_LIMIT)
      begin
         if (be[0])
            state_next.win1_limit[7:CIRQ_LIMIT_LSB] =
               wdata[7:CIRQ_LIMIT_LSB];
         if (be[1])
            state_next.win1_limit[CIRQ_LIMIT_MSB:8] =
               wdata[CIRQ_LIMIT_MSB:8];
      end
      else if (wr_en && addr == CIRQ_OFF_IRQ_SCRATCH && be[0])
      begin
         state_next.scratch = wdata[7:0];
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg.win0_limit <= CIRQ_LIMIT_RESET;
         state_reg.win1_limit <= CIRQ_LIMIT_RESET;
         state_reg.scratch    <= CIRQ_SCRATCH_RESET;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign state = state_reg;

endmodule

// ==== rtl/cirq_config_irq_io_limit_regs.sv ====
// Configuration slice: I/O window limits, interrupt line and interrupt pin
`timescale 1ns/1ps

module cirq_config_irq_io_limit_regs
   import cirq_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire cirq_cfg_req_s          cfg_req,
   output logic [31:0]                 cfg_rdata,
   output logic                        cfg_rvalid,
   input  wire logic [1:0][1:0][31:0]  io_window_base,
   input  wire logic                   pair_irq_merge,
   input  wire logic                   all_irq_merge,
   input  wire logic [2:0]             func_irq,
   output logic [1:0][1:0]             io_window_en,
   output logic [2:0]                  shared_irq
);

   // ------------------------------------------------------------------
   // Per-function register slices
   // ------------------------------------------------------------------
   cirq_func_state_s [CIRQ_NUM_FUNC-1:0] func_state;
   logic [CIRQ_NUM_FUNC-1:0]             func_wr;

   genvar g;
   generate
      for (g = 0; g < CIRQ_NUM_FUNC; g = g + 1)
      begin : gen_func
         assign func_wr[g] = cfg_req.wr && (cfg_req.func == 2'(g));
         cirq_func_regs
         #(
            .HAS_IO_WINDOWS (g < CIRQ_NUM_WIN)
         )
         u_regs
         (
            .clk            (clk),
            .rst            (rst),
            .wr_en          (func_wr[g]),
            .addr           (cfg_req.addr),
            .be             (cfg_req.be),
            .wdata          (cfg_req.wdata),
            .state          (func_state[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Interrupt pin report per function
   // ------------------------------------------------------------------
   logic [7:0] pin_value [CIRQ_NUM_FUNC];

   always_comb
   begin
      pin_value[0] = CIRQ_PIN_FIRST;
      pin_value[1] = CIRQ_PIN_SECOND;
      pin_value[2] = CIRQ_PIN_THIRD;
      if (all_irq_merge)
      begin
         pin_value[1] = CIRQ_PIN_FIRST;
         pin_value[2] = CIRQ_PIN_FIRST;
      end
      else if (pair_irq_merge)
      begin
         pin_value[1] = CIRQ_PIN_FIRST;
      end
   end

   // ------------------------------------------------------------------
   // Configuration read path
   // ------------------------------------------------------------------
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [7:0]  dword_addr;
   logic [7:0]  irq_pin_report_value;

   assign dword_addr = {cfg_req.addr[7:2], 2'b00};

   always_comb
   begin
      rdata_next           = CIRQ_READ_ZERO;
      rvalid_next          = cfg_req.rd;
      irq_pin_report_value = 8'h00;
      if (cfg_req.func < CIRQ_NUM_FUNC)
      begin
         irq_pin_report_value = pin_value[cfg_req.func];
      end
      if (!cfg_req.rd || cfg_req.func >= CIRQ_NUM_FUNC)
      begin
         rdata_next = CIRQ_READ_ZERO;
      end
      else if (dword_addr == CIRQ_OFF_IO_WIN0_LIMIT &&
               cfg_req.func < CIRQ_NUM_WIN)
      begin
         rdata_next[CIRQ_LIMIT_MSB:CIRQ_LIMIT_LSB] =
            func_state[cfg_req.func].win0_limit
               [CIRQ_LIMIT_MSB:CIRQ_LIMIT_LSB];
      end
      else if (dword_addr == CIRQ_OFF_IO_WIN1_LIMIT &&
               cfg_req.func < CIRQ_NUM_WIN)
      begin
         rdata_next[CIRQ_LIMIT_MSB:CIRQ_LIMIT_LSB] =
            func_state[cfg_req.func].win1_limit
               [CIRQ_LIMIT_MSB:CIRQ_LIMIT_LSB];
      end
      else if (dword_addr == CIRQ_OFF_IRQ_SCRATCH)
      begin
         rdata_next[7:0]  = func_state[cfg_req.func].scratch;
         rdata_next[15:8] = irq_pin_report_value;
      end
      else
      begin
         rdata_next = CIRQ_READ_ZERO;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_reg  <= CIRQ_READ_ZERO;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign cfg_rdata  = rdata_reg;
   assign cfg_rvalid = rvalid_reg;

   // ------------------------------------------------------------------
   // I/O window forwarding enables
   // ------------------------------------------------------------------
   logic [1:0][1:0] win_en_reg;
   logic [1:0][1:0] win_en_next;

   always_comb
   begin
      for (int f = 0; f < CIRQ_NUM_WIN; f++)
      begin
         win_en_next[f][0] = (io_window_base[f][0] != CIRQ_LIMIT_RESET) ||
                             (func_state[f].win0_limit !=
                              CIRQ_LIMIT_RESET);
         win_en_next[f][1] = (io_window_base[f][1] != CIRQ_LIMIT_RESET) ||
                             (func_state[f].win1_limit !=
                              CIRQ_LIMIT_RESET);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         win_en_reg <= '0;
      end
      else
      begin
         win_en_reg <= win_en_next;
      end
   end

   assign io_window_en = win_en_reg;

   // ------------------------------------------------------------------
   // Internal interrupt wiring onto the shared pins
   // ------------------------------------------------------------------
   logic [2:0] irq_reg;
   logic [2:0] irq_next;

   always_comb
   begin
      irq_next = func_irq;
      if (all_irq_merge)
      begin
         irq_next = {2'b00, |func_irq};
      end
      else if (pair_irq_merge)
      begin
         irq_next = {func_irq[2], 1'b0,
                     func_irq[0] | func_irq[1]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_reg <= 3'h0;
      end
      else
      begin
         irq_reg <= irq_next;
      end
   end

   assign shared_irq = irq_reg;

endmodule

// ==== bench/cirq_limit_properties.sv ====
// Checker for the interrupt and I/O limit configuration slice
`timescale 1ns/1ps
module cirq_limit_properties
   import cirq_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire cirq_cfg_req_s         cfg_req,
   input  wire logic [31:0]           cfg_rdata,
   input  wire logic                  cfg_rvalid,
   input  wire logic [1:0][1:0][31:0] io_window_base,
   input  wire logic                  pair_irq_merge,
   input  wire logic                  all_irq_merge,
   input  wire logic [2:0]            func_irq,
   input  wire logic [1:0][1:0]       io_window_en,
   input  wire logic [2:0]            shared_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic pr;
   logic lr;
   assign pr = cfg_req.rd && cfg_req.addr[7:2] == 6'h0F;
   assign lr = cfg_req.rd && cfg_req.func != 2'h3
               && (cfg_req.addr[7:2] == 6'h0C || cfg_req.addr[7:2] == 6'h0E);
   // ------------------------------------------------------------------
   // Assertions and cover points
   // ------------------------------------------------------------------
   a_rvalid_after_rd: assert property (cfg_req.rd |=> cfg_rvalid)
      else $error("read answer missing");
   a_idle_rdata_zero: assert property
      (!cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 32'h0)
      else $error("read answer without read");
   a_pin_func_zero: assert property
      (pr && cfg_req.func == 2'h0 |=> cfg_rdata[15:8] == 8'h01)
      else $error("function 0 pin wrong");
   a_pin_func_one: assert property (pr && cfg_req.func == 2'h1 |=>
      cfg_rdata[15:8] == (($past(pair_irq_merge) || $past(all_irq_merge))
      ? 8'h01 : 8'h02)) else $error("function 1 pin wrong");
   a_pin_func_two: assert property (pr && cfg_req.func == 2'h2 |=>
      cfg_rdata[15:8] == ($past(all_irq_merge) ? 8'h01 : 8'h03))
      else $error("function 2 pin wrong");
   a_limit_fixed_bits: assert property
      (lr |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[1:0] == 2'h0)
      else $error("limit fixed bits nonzero");
   a_scratch_upper: assert property (pr |=> cfg_rdata[31:16] == 16'h0)
      else $error("scratch dword upper half nonzero");
   a_window_enable: assert property
      (io_window_base[0][1] != 32'h0 |=> io_window_en[0][1])
      else $error("window with nonzero base disabled");
   a_tie_all_irq: assert property
      (all_irq_merge && func_irq != 3'h0 |=> shared_irq == 3'h1)
      else $error("all merge output wrong");
   a_tie_pair_irq: assert property (pair_irq_merge && !all_irq_merge |=>
      !shared_irq[1] && shared_irq[0] == $past(func_irq[0] | func_irq[1]))
      else $error("pair merge output wrong");
   c_pin_read: cover property (pr ##1 cfg_rvalid);
   c_all_merge: cover property (all_irq_merge && func_irq != 3'h0);
   c_pair_merge: cover property (pair_irq_merge ##1 shared_irq[0]);
endmodule

// ==== bench/cirq_host_model.sv ====
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module cirq_host_model
   import cirq_pkg::*;
(
   input  wire logic        clk,
   output cirq_cfg_req_s    cfg_req,
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_rvalid
);
   initial cfg_req = '0;
   task automatic wr(input logic [1:0] f, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
      @(posedge clk);
      #1 cfg_req = '{1'b0, 1'b1, f, a, b, d};
      @(posedge clk);
      #1 cfg_req.wr = 1'b0;
      cfg_req.wdata = ~d;
   endtask
   task automatic rd(input logic [1:0] f, input logic [7:0] a,
                     output logic [31:0] d, output logic v);
      @(posedge clk);
      #1 cfg_req = '{1'b1, 1'b0, f, a, 4'h0, 32'h0};
      @(posedge clk);
      #1 cfg_req.rd = 1'b0;
      d = cfg_rdata;
      v = cfg_rvalid;
   endtask
endmodule

// ==== bench/cirq_config_irq_io_limit_regs_tb_top.sv ====
// Testbench for the interrupt and I/O limit configuration slice
`timescale 1ns/1ps
module cirq_config_irq_io_limit_regs_tb_top
   import cirq_pkg::*;
;
   logic                  clk;
   logic                  rst;
   cirq_cfg_req_s         cfg_req;
   logic [31:0]           cfg_rdata;
   logic [31:0]           d;
   logic                  cfg_rvalid;
   logic                  v;
   logic                  pair_irq_merge;
   logic                  all_irq_merge;
   logic [1:0][1:0][31:0] base;
   logic [2:0]            func_irq;
   logic [2:0]            sh;
   logic [1:0][1:0]       en;
   logic [7:0]            pin;
   int                    fail_count;
   int                    n_compared;
   cirq_config_irq_io_limit_regs uut (.clk(clk), .rst(rst),
      .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .io_window_base(base), .pair_irq_merge(pair_irq_merge),
      .all_irq_merge(all_irq_merge), .func_irq(func_irq),
      .io_window_en(en), .shared_irq(sh));
   cirq_host_model host (.clk(clk), .cfg_req(cfg_req),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [1:0] f, input logic [7:0] a,
                       input logic [31:0] e);
      host.rd(f, a, d, v);
      chk("rvalid", 32'h1, {31'h0, v});
      chk("rdata", e, d);
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (2000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial
   begin
      rst = 1'b1;
      pair_irq_merge = 1'b0;
      all_irq_merge = 1'b0;
      func_irq = 3'h6;
      base = '0;
      fail_count = 0;
      n_compared = 0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      for (int f = 0; f < 2; f++)
      begin
         rchk(f[1:0], 8'h30, 32'h0);
         rchk(f[1:0], 8'h38, 32'h0);
      end
      rchk(2'h0, 8'h3C, 32'h01FF);
      rchk(2'h1, 8'h3C, 32'h02FF);
      rchk(2'h2, 8'h3C, 32'h03FF);
      host.wr(2'h0, 8'h30, 4'hF, 32'hFFFF_FFFF);
      host.wr(2'h1, 8'h38, 4'h3, 32'h1234_5679);
      rchk(2'h0, 8'h30, 32'h0000_FFFC);
      rchk(2'h1, 8'h38, 32'h0000_5678);
      rchk(2'h1, 8'h30, 32'h0);
      host.wr(2'h1, 8'h3C, 4'hF, 32'hFFFF_7EA5);
      rchk(2'h1, 8'h3C, 32'h02A5);
      rchk(2'h0, 8'h3C, 32'h01FF);
      host.wr(2'h0, 8'h3D, 4'h2, 32'h0000_5500);
      host.wr(2'h3, 8'h3C, 4'h1, 32'h0000_0011);
      host.wr(2'h2, 8'h30, 4'h3, 32'h0000_FFFF);
      rchk(2'h0, 8'h3D, 32'h01FF);
      rchk(2'h3, 8'h3C, 32'h0);
      rchk(2'h2, 8'h30, 32'h0);
      rchk(2'h1, 8'h3D, 32'h02A5);
      base[0][1] = 32'h0000_1000;
      repeat (2) @(posedge clk);
      #1 chk("window_en", 32'hB, {28'h0, en});
      for (int t = 0; t < 4; t++)
      begin
         {all_irq_merge, pair_irq_merge} = t[1:0];
         rchk(2'h0, 8'h3C, 32'h01FF);
         pin = (t != 0) ? 8'h01 : 8'h02;
         rchk(2'h1, 8'h3C, {16'h0, pin, 8'hA5});
         pin = t[1] ? 8'h01 : 8'h03;
         rchk(2'h2, 8'h3C, {16'h0, pin, 8'hFF});
         pin = t[1] ? 8'h01 : (t[0] ? 8'h05 : 8'h06);
         chk("shared_irq", {24'h0, pin}, {29'h0, sh});
      end
      conclude();
   end
endmodule
bind cirq_config_irq_io_limit_regs cirq_limit_properties u_prop (
   .clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid), .io_window_base(io_window_base),
   .pair_irq_merge(pair_irq_merge), .all_irq_merge(all_irq_merge),
   .func_irq(func_irq), .io_window_en(io_window_en),
   .shared_irq(shared_irq));
